// ### verilog/wsc_pkg.sv
package wsc_pkg;

	// Source count and lane layout
	localparam int          NUM_SRC   = 4;
	localparam int          LANE_W    = 8;
	localparam int          SEL_LSB   = 4;
	localparam int          SEL_W     = 3;
	localparam int          REC_LSB   = 2;
	localparam int          REC_W     = 2;
	localparam int          EN_BIT    = 0;
	localparam int          ADR_W     = 8;
	localparam int          DAT_W     = 32;
	localparam int          SEL_BYTES = 4;

	// Word offsets
	localparam logic [7:0]  OFS_CTRL_8_TO_B = 8'h00;
	localparam logic [7:0]  OFS_CTRL_C_TO_F = 8'h04;
	localparam logic [7:0]  OFS_INT_CLEAR   = 8'h08;
	localparam logic [7:0]  OFS_INT_STATUS  = 8'h0C;
	localparam logic [7:0]  OFS_INT_MASK    = 8'h10;

	// Detection codes
	typedef enum logic [2:0] {
		DET_LOW  = 3'h0,
		DET_HIGH = 3'h1,
		DET_FALL = 3'h2,
		DET_RISE = 3'h3,
		DET_BOTH = 3'h4
	} wsc_detect_e;

	// Edge record codes
	localparam logic [1:0]  REC_NONE = 2'h0;
	localparam logic [1:0]  REC_RISE = 2'h1;
	localparam logic [1:0]  REC_FALL = 2'h2;

	// Reset values
	localparam logic [2:0]  SEL_RST  = 3'h2;
	localparam logic [1:0]  REC_RST  = 2'h0;
	localparam logic        EN_RST   = 1'b0;
	localparam logic [3:0]  MASK_RST = 4'h0;
	localparam logic [31:0] DAT_ZERO = 32'h0000_0000;

	// Wishbone request from the master
	typedef struct packed {
		logic                 cyc;
		logic                 stb;
		logic                 we;
		logic [ADR_W-1:0]     adr;
		logic [SEL_BYTES-1:0] sel;
		logic [DAT_W-1:0]     dat;
	} wsc_wb_req_s;

	// Wishbone answer to the master
	typedef struct packed {
		logic             ack;
		logic [DAT_W-1:0] dat;
	} wsc_wb_rsp_s;

endpackage : wsc_pkg

// ### verilog/wsc_edge_detect.sv
`timescale 1ns/1ps
module wsc_edge_detect (
	// Clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_rst,
	// Pin and mode
	input  wire logic                 i_level,
	input  wire wsc_pkg::wsc_detect_e i_mode,
	// Detection
	output logic                      o_hit,
	output logic                      o_rise,
	output logic                      o_fall
);
	import wsc_pkg::*;

	typedef struct packed {
		logic prev;
		logic primed;
	} wsc_det_state_s;

	wsc_det_state_s state;
	wsc_det_state_s next_state;
	logic           rise;
	logic           fall;

	// No edge before the first sample, avoids a false edge out of reset
	assign rise = state.primed & ~state.prev & i_level;
	assign fall = state.primed & state.prev & ~i_level;
	assign o_rise = rise;
	assign o_fall = fall;

	always_comb begin
		next_state        = state;
		next_state.prev   = i_level;
		next_state.primed = 1'b1;
		case (i_mode)
			DET_LOW:  o_hit = ~i_level;
			DET_HIGH: o_hit = i_level;
			DET_FALL: o_hit = fall;
			DET_RISE: o_hit = rise;
			DET_BOTH: o_hit = rise | fall;
			default:  o_hit = 1'b0;
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

endmodule : wsc_edge_detect

// ### verilog/wsc_wake_config.sv
`timescale 1ns/1ps
// Overview of operation
// - Selector picks low, high, falling, rising, both.
// - Two-bit record shows rising, falling or both.
// - Record meaningful only in both-edge mode.
// - Software reads back the edge that woke.
// - Interrupt clear also zeroes the edge record.
// - Sources B,A,9,8 occupy lanes top to bottom.
module wsc_wake_config (
	// Clock and reset
	input  wire logic                           i_clock,
	input  wire logic                           i_rst,
	// Register bus
	input  wire wsc_pkg::wsc_wb_req_s           i_wb,
	output wsc_pkg::wsc_wb_rsp_s                o_wb,
	// Wake source pins, bit 0 is source 8
	input  wire logic [wsc_pkg::NUM_SRC-1:0]    i_wake_src,
	// Results
	output logic                                o_wake_req,
	output logic                                o_irq
);
	import wsc_pkg::*;

	typedef struct packed {
		logic                            ack;
		logic [DAT_W-1:0]                rdata;
		logic [NUM_SRC-1:0][SEL_W-1:0]   sel;
		logic [NUM_SRC-1:0][REC_W-1:0]   rec;
		logic [NUM_SRC-1:0]              en;
		logic [NUM_SRC-1:0][SEL_W-1:0]   sel_hi;
		logic [NUM_SRC-1:0]              en_hi;
		logic [NUM_SRC-1:0]              pend;
		logic [NUM_SRC-1:0]              mask;
		logic                            irq;
		logic                            wake;
	} wsc_state_s;

	wsc_state_s         state;
	wsc_state_s         next_state;
	logic [NUM_SRC-1:0] hit;
	logic [NUM_SRC-1:0] rise;
	logic [NUM_SRC-1:0] fall;

	// Per-source detectors
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_src
			wsc_edge_detect u_det (
				.i_clock (i_clock),
				.i_rst   (i_rst),
				.i_level (i_wake_src[g]),
				.i_mode  (wsc_detect_e'(state.sel[g])),
				.o_hit   (hit[g]),
				.o_rise  (rise[g]),
				.o_fall  (fall[g])
			);
		end
	endgenerate

	// Pack one control register from its fields
	function automatic logic [DAT_W-1:0] pack_ctrl(
		input logic [NUM_SRC-1:0][SEL_W-1:0] s,
		input logic [NUM_SRC-1:0][REC_W-1:0] r,
		input logic [NUM_SRC-1:0]            e
	);
		logic [DAT_W-1:0] v;
		v = DAT_ZERO;
		for (int i = 0; i < NUM_SRC; i++) begin
			v[LANE_W*i+SEL_LSB +: SEL_W] = s[i];
			v[LANE_W*i+REC_LSB +: REC_W] = r[i];
			v[LANE_W*i+EN_BIT]           = e[i];
		end
		// top bit and spare bit stay zero
		return v;
	endfunction : pack_ctrl

	logic                req;
	logic [NUM_SRC-1:0]  clr_int;
	logic [NUM_SRC-1:0]  clr_stat;
	logic [NUM_SRC-1:0]  set_pend;
	logic [DAT_W-1:0]    wd;

	always_comb begin
		next_state      = state;
		next_state.ack  = 1'b0;
		next_state.wake = 1'b0;
		clr_int         = '0;
		clr_stat        = '0;
		wd              = i_wb.dat;
		// One wait-free answer per request, ack dropped next cycle
		req             = i_wb.cyc & i_wb.stb & ~state.ack;

		if (req) begin
			next_state.ack = 1'b1;
			if (i_wb.we) begin
				case (i_wb.adr)
					OFS_CTRL_8_TO_B: begin
						for (int i = 0; i < NUM_SRC; i++) begin
							if (i_wb.sel[i]) begin
								// enable gates wake, selector order is software's
								next_state.sel[i] = wd[LANE_W*i+SEL_LSB +: SEL_W];
								next_state.en[i]  = wd[LANE_W*i+EN_BIT];
							end
						end
					end
					OFS_CTRL_C_TO_F: begin
						for (int i = 0; i < NUM_SRC; i++) begin
							if (i_wb.sel[i]) begin
								next_state.sel_hi[i] = wd[LANE_W*i+SEL_LSB +: SEL_W];
								next_state.en_hi[i]  = wd[LANE_W*i+EN_BIT];
							end
						end
					end
					OFS_INT_CLEAR: begin
						if (i_wb.sel[0]) begin
							clr_int = wd[NUM_SRC-1:0];
						end
					end
					OFS_INT_STATUS: begin
						if (i_wb.sel[0]) begin
							clr_stat = wd[NUM_SRC-1:0];
						end
					end
					OFS_INT_MASK: begin
						if (i_wb.sel[0]) begin
							next_state.mask = wd[NUM_SRC-1:0];
						end
					end
					default: begin
						// Unmapped write is acked and dropped
					end
				endcase
				next_state.rdata = DAT_ZERO;
			end else begin
				case (i_wb.adr)
					OFS_CTRL_8_TO_B: next_state.rdata = pack_ctrl(state.sel, state.rec, state.en);
					OFS_CTRL_C_TO_F: next_state.rdata = pack_ctrl(state.sel_hi, '0, state.en_hi);
					OFS_INT_STATUS:  next_state.rdata = {{(DAT_W-NUM_SRC){1'b0}}, state.pend};
					OFS_INT_MASK:    next_state.rdata = {{(DAT_W-NUM_SRC){1'b0}}, state.mask};
					default:         next_state.rdata = DAT_ZERO;
				endcase
			end
		end

		// Only enabled sources raise a wake request
		set_pend = hit & state.en;

		for (int i = 0; i < NUM_SRC; i++) begin
			// clear register also zeroes the record
			if (clr_int[i]) begin
				next_state.rec[i] = REC_NONE;
			end
			if (set_pend[i] && state.sel[i] == DET_BOTH) begin
				next_state.rec[i] = (clr_int[i] ? REC_NONE : state.rec[i])
					| (rise[i] ? REC_RISE : REC_NONE)
					| (fall[i] ? REC_FALL : REC_NONE);
			end
		end

		// New event wins over a clear in the same cycle
		next_state.pend = (state.pend & ~(clr_int | clr_stat)) | set_pend;
		next_state.irq  = |(next_state.pend & next_state.mask);
		next_state.wake = |set_pend;
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state.ack    <= 1'b0;
			state.rdata  <= DAT_ZERO;
			state.sel    <= {NUM_SRC{SEL_RST}};
			state.rec    <= {NUM_SRC{REC_RST}};
			state.en     <= {NUM_SRC{EN_RST}};
			state.sel_hi <= {NUM_SRC{SEL_RST}};
			state.en_hi  <= {NUM_SRC{EN_RST}};
			state.pend   <= '0;
			state.mask   <= MASK_RST;
			state.irq    <= 1'b0;
			state.wake   <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// All outputs straight from flops
	assign o_wb.ack   = state.ack;
	assign o_wb.dat   = state.rdata;
	assign o_irq      = state.irq;
	assign o_wake_req = state.wake;

endmodule : wsc_wake_config

// ### tb/wsc_wake_config_assertions.sv
`timescale 1ns/1ps
module wsc_wake_config_checker (
	// Clock and reset
	input wire logic                          i_clock,
	input wire logic                          i_rst,
	// Watched ports
	input wire wsc_pkg::wsc_wb_req_s          i_wb,
	input wire wsc_pkg::wsc_wb_rsp_s          o_wb,
	input wire logic [wsc_pkg::NUM_SRC-1:0]   i_wake_src,
	input wire logic                          o_wake_req,
	input wire logic                          o_irq
);
	import wsc_pkg::*;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	logic req;
	logic rd;
	logic seen;
	assign req = i_wb.cyc && i_wb.stb;
	assign rd  = o_wb.ack && !i_wb.we;
	// No interrupt can exist before a wake
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			seen <= 1'b0;
		end else if (o_wake_req) begin
			seen <= 1'b1;
		end
	end
	chk_ack_answer: assert property (req && !o_wb.ack |=> o_wb.ack)
		else $error("request not answered");
	chk_ack_pulse: assert property (o_wb.ack |=> !o_wb.ack)
		else $error("ack too long");
	chk_ack_cause: assert property (!req |=> !o_wb.ack)
		else $error("ack without request");
	chk_lane_top: assert property (rd && i_wb.adr[7:3] == 5'h00 |-> (o_wb.dat & 32'h8282_8282) == '0)
		else $error("reserved bit set");
	chk_clear_reads: assert property (rd && i_wb.adr == OFS_INT_CLEAR |-> o_wb.dat == '0)
		else $error("clear reads nonzero");
	chk_write_zero: assert property (o_wb.ack && i_wb.we |-> o_wb.dat == '0)
		else $error("write data nonzero");
	chk_unmapped_zero: assert property (rd && i_wb.adr > OFS_INT_MASK |-> o_wb.dat == '0)
		else $error("unmapped nonzero");
	chk_irq_cause: assert property (!seen && !o_wake_req |-> !o_irq)
		else $error("irq before wake");
	cov_read: cover property (rd);
	cov_wake: cover property (o_wake_req);
	cov_irq: cover property ($rose(o_irq));
endmodule : wsc_wake_config_checker

bind wsc_wake_config wsc_wake_config_checker CHK (.i_clock(i_clock), .i_rst(i_rst), .i_wb(i_wb),
	.o_wb(o_wb), .i_wake_src(i_wake_src), .o_wake_req(o_wake_req), .o_irq(o_irq));

// ### tb/wsc_pin_model.sv
`timescale 1ns/1ps
module wsc_pin_model (
	// Clock
	input  wire logic  i_clock,
	// Wake pins, pulled up
	output logic [3:0] o_pins
);
	initial o_pins = 4'hF;
	// Slow answers wait more edges
	task automatic drive(input logic [3:0] v, input int slow);
		repeat (slow) @(posedge i_clock);
		o_pins <= v;
	endtask : drive
endmodule : wsc_pin_model

// ### tb/test_standby_wake_source_config.sv
`timescale 1ns/1ps
module test_standby_wake_source_config;
	import wsc_pkg::*;
	`define CMP(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
		$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
	logic        i_clock = 1'b0;
	logic        i_rst = 1'b1;
	wsc_wb_req_s i_wb = '0;
	wsc_wb_rsp_s o_wb;
	logic [3:0]  pins;
	logic        o_wake_req;
	logic        o_irq;
	logic [31:0] rdat;
	wsc_detect_e mode;
	logic        pre;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          n_wake = 0;
	int          w0;
	wsc_wake_config DUT (.i_clock(i_clock), .i_rst(i_rst), .i_wb(i_wb), .o_wb(o_wb),
		.i_wake_src(pins), .o_wake_req(o_wake_req), .o_irq(o_irq));
	wsc_pin_model PINS (.i_clock(i_clock), .o_pins(pins));
	always #10 i_clock = ~i_clock;
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude
	// Hang guard, run needs under 1000 cycles
	// Wake pulses seen so far
	always @(posedge i_clock) begin
		if (o_wake_req === 1'b1) begin
			n_wake++;
		end
	end
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		i_wb <= '{cyc: 1'b1, stb: 1'b1, we: 1'b1, adr: a, sel: s, dat: d};
		@(posedge i_clock);
		// No fixed latency assumed, only the hang guard ends a wait
		while (o_wb.ack !== 1'b1) begin
			@(posedge i_clock);
		end
		rdat = o_wb.dat;
		i_wb <= '0;
		@(posedge i_clock);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		i_wb <= '{cyc: 1'b1, stb: 1'b1, we: 1'b0, adr: a, sel: 4'hF, dat: '0};
		@(posedge i_clock);
		while (o_wb.ack !== 1'b1) begin
			@(posedge i_clock);
		end
		rdat = o_wb.dat;
		i_wb <= '0;
		@(posedge i_clock);
		`CMP(rdat, e)
	endtask : rd
	task automatic note(input string s);
		$display("test %s done", s);
	endtask : note
	initial begin
		repeat (20) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		rd(OFS_CTRL_8_TO_B, 32'h2020_2020);
		rd(OFS_CTRL_C_TO_F, 32'h2020_2020);
		rd(8'h40, DAT_ZERO);
		note("reset");
		wr(OFS_CTRL_8_TO_B, 32'hCE4E_CECE);
		rd(OFS_CTRL_8_TO_B, 32'h4040_4040);
		wr(OFS_CTRL_8_TO_B, 32'h4141_4141);
		rd(OFS_CTRL_8_TO_B, 32'h4141_4141);
		wr(OFS_INT_MASK, 32'h1);
		note("layout");
		w0 = n_wake;
		PINS.drive(4'hE, 1);
		repeat (3) @(posedge i_clock);
		rd(OFS_CTRL_8_TO_B, 32'h4141_4149);
		`CMP(o_irq, 1'b1)
		`CMP(n_wake - w0, 1)
		PINS.drive(4'hF, 2);
		repeat (3) @(posedge i_clock);
		rd(OFS_CTRL_8_TO_B, 32'h4141_414D);
		rd(OFS_INT_STATUS, 32'h1);
		wr(OFS_INT_CLEAR, 32'h1);
		rd(OFS_CTRL_8_TO_B, 32'h4141_4141);
		`CMP(o_irq, 1'b0)
		PINS.drive(4'hD, 1);
		repeat (3) @(posedge i_clock);
		rd(OFS_INT_STATUS, 32'h2);
		`CMP(o_irq, 1'b0)
		wr(OFS_INT_STATUS, 32'h2);
		rd(OFS_CTRL_8_TO_B, 32'h4141_4941);
		note("record");
		// Only the enable changes here
		wr(OFS_CTRL_8_TO_B, 32'h4000_0000, 4'h8);
		// Codes 101 to 111 are never written
		for (int c = 0; c < 4; c++) begin
			mode = wsc_detect_e'(c);
			pre = (c == 1 || c == 3) ? 1'b0 : 1'b1;
			wr(OFS_CTRL_8_TO_B, {1'b0, mode, 28'h0}, 4'h8);
			PINS.drive({pre, 3'b101}, 1);
			wr(OFS_CTRL_8_TO_B, {1'b0, mode, 28'h100_0000}, 4'h8);
			wr(OFS_INT_STATUS, 32'h8);
			rd(OFS_INT_STATUS, DAT_ZERO);
			w0 = n_wake;
			PINS.drive({~pre, 3'b101}, 1);
			repeat (3) @(posedge i_clock);
			rd(OFS_INT_STATUS, 32'h8);
			`CMP(n_wake != w0, 1'b1)
			wr(OFS_CTRL_8_TO_B, {1'b0, mode, 28'h0}, 4'h8);
		end
		note("modes");
		conclude();
	end
endmodule : test_standby_wake_source_config
